// ===== aspbg_pkg.sv
// constants, state types and reset values for the asynchronous serial port with baud generator
// Behaviour
// - receive buffer separate from receive shifter
// - accepted data buffer writes always feed transmitter
// - data buffer reads return receive buffer
// - transmit holding data cannot be read back
// - interrupt request when enabled and flag set
// - flags not cleared on interrupt entry
// - transmit clock from baud timer low overflows
// - hidden receive timer copy shares reload byte
// - both overflow streams divided by two
// - start condition forces receive timer reload
// - overflow every 256 minus reload counts
// - six selectable baud timer clock sources
// - mode bit selects 8 or 9-bit frames
// - 8-bit frame: start, 8 data lsb-first, stop
// - 8-bit receive stores data, stop to ninth
// - data write starts transmission
// - transmit done set at stop bit start
// - receive only while receive enable set
// - accept only if not done, stop checked
// - failed acceptance updates nothing
// - overrun keeps first byte, drops new frame
// - 9-bit frame: eleven bits, ninth bit fields
package aspbg_pkg;

  localparam int ASPBG_DATA_W = 8;
  localparam int ASPBG_FIFO_DEPTH = 8;
  localparam int ASPBG_TIMER_W = 8;

  // bits after the start bit, stop included, per frame mode
  localparam logic [3:0] ASPBG_LAST_8BIT = 4'h9;
  localparam logic [3:0] ASPBG_LAST_9BIT = 4'ha;
  localparam logic [3:0] ASPBG_START_IDX = 4'h0;

  // prescaler terminal counts for the baud timer clock sources
  localparam logic [1:0] ASPBG_PRE4_LAST = 2'h3;
  localparam logic [3:0] ASPBG_PRE12_LAST = 4'hb;
  localparam logic [1:0] ASPBG_PRE48_LAST = 2'h3;
  localparam logic [2:0] ASPBG_OSC8_LAST = 3'h7;

  typedef enum logic [2:0] {
    ASPBG_SRC_SYS = 3'h0,
    ASPBG_SRC_DIV4 = 3'h1,
    ASPBG_SRC_DIV12 = 3'h2,
    ASPBG_SRC_DIV48 = 3'h3,
    ASPBG_SRC_OSC8 = 3'h4,
    ASPBG_SRC_EXTPIN = 3'h5
  } aspbg_clk_src_t;

  typedef enum logic {
    ASPBG_TX_IDLE = 1'b0,
    ASPBG_TX_SEND = 1'b1
  } aspbg_tx_state_t;

  typedef enum logic {
    ASPBG_RX_IDLE = 1'b0,
    ASPBG_RX_RECV = 1'b1
  } aspbg_rx_state_t;

  typedef struct packed {
    aspbg_tx_state_t tx_state;
    logic [3:0] tx_cnt;
    logic [9:0] tx_shift;
    logic tx_pin;
    logic tx_half;
    aspbg_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [8:0] rx_shift;
    logic rx_half;
    logic [7:0] rx_buf;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
    logic [2:0] rx_sync;
    logic rx_level;
    logic [2:0] ext_sync;
    logic ext_level;
    logic [2:0] osc_sync;
    logic osc_level;
    logic [2:0] osc_cnt;
    logic [1:0] pre4;
    logic [3:0] pre12;
    logic [1:0] pre48;
  } aspbg_state_t;

  // line and receive synchroniser reset to idle-high so no false start is seen
  localparam aspbg_state_t ASPBG_STATE_RESET = '{
    tx_state: ASPBG_TX_IDLE, tx_cnt: 4'h0, tx_shift: 10'h3ff, tx_pin: 1'b1, tx_half: 1'b0,
    rx_state: ASPBG_RX_IDLE, rx_cnt: 4'h0, rx_shift: 9'h000, rx_half: 1'b0,
    rx_buf: 8'h00, rx_ninth: 1'b0, tx_done: 1'b0, rx_done: 1'b0,
    rx_sync: 3'h7, rx_level: 1'b1, ext_sync: 3'h0, ext_level: 1'b0,
    osc_sync: 3'h0, osc_level: 1'b0, osc_cnt: 3'h0, pre4: 2'h0, pre12: 4'h0, pre48: 2'h0
  };

endpackage : aspbg_pkg

// ===== aspbg_fifo.sv
// transmit data fifo with valid/ready on both sides
`timescale 1ns/1ns
module aspbg_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } aspbg_fifo_st_t;

  aspbg_fifo_st_t r;
  aspbg_fifo_st_t n;
  logic push;
  logic pop;

  // honest full and empty straight from the occupancy count
  assign in_ready = (r.count != (AW+1)'(D));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer wrap handles depths that are not a power of two
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wptr] = in_data;
      n.wptr = (r.wptr == AW'(D-1)) ? '0 : r.wptr + AW'(1);
    end
    if (pop) begin
      n.rptr = (r.rptr == AW'(D-1)) ? '0 : r.rptr + AW'(1);
    end
    n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : aspbg_fifo

// ===== aspbg_reload_timer.sv
// 8-bit auto-reload counter used for both the transmit and the hidden receive baud timer
`timescale 1ns/1ns
module aspbg_reload_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic force_load,
  input wire logic [W-1:0] reload,
  output logic ovf,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } aspbg_tmr_st_t;

  aspbg_tmr_st_t r;
  aspbg_tmr_st_t n;

  // overflow on the tick that leaves the all-ones count
  assign ovf = tick && (r.cnt == {W{1'b1}}) && !force_load;
  assign count = r.cnt;

  // forced load wins so a start bit realigns the phase at once
  always_comb begin
    n = r;
    if (force_load || ovf) begin
      n.cnt = reload;
    end else if (tick) begin
      n.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  a_reload_after_ovf: assert property (@(posedge clk) disable iff (!rst_b) ovf |=> r.cnt == $past(reload))
    else $error("timer did not reload after overflow");

endmodule : aspbg_reload_timer

// ===== aspbg_top.sv
// asynchronous serial port: baud generation, transmitter with fifo, buffered receiver
`timescale 1ns/1ns
module aspbg_top
  import aspbg_pkg::*;
#(
  parameter int FIFO_DEPTH = ASPBG_FIFO_DEPTH
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SERIAL_DATA_BUFFER_WR,
  input wire logic [ASPBG_DATA_W-1:0] SERIAL_DATA_BUFFER_WDATA,
  output logic SERIAL_DATA_BUFFER_WR_READY,
  output logic [ASPBG_DATA_W-1:0] SERIAL_DATA_BUFFER_RDATA,
  input wire logic FRAME_MODE_SELECT,
  input wire logic STOP_OR_ADDRESS_CHECK_ENABLE,
  input wire logic RECEIVE_ENABLE_BIT,
  input wire logic TRANSMIT_NINTH_BIT,
  output logic RECEIVED_NINTH_BIT,
  output logic TRANSMIT_DONE_FLAG,
  output logic RECEIVE_DONE_FLAG,
  input wire logic TRANSMIT_DONE_CLEAR,
  input wire logic RECEIVE_DONE_CLEAR,
  input wire logic PORT_IRQ_ENABLE,
  output logic PORT_IRQ,
  input wire logic BAUD_TIMER_RUN,
  input wire logic [2:0] BAUD_TIMER_CLK_SEL,
  input wire logic [ASPBG_TIMER_W-1:0] BAUD_TIMER_RELOAD_BYTE,
  input wire logic EXT_OSC_CLK_PIN,
  input wire logic BAUD_TIMER_EXT_INPUT,
  output logic SERIAL_TX_PIN,
  input wire logic SERIAL_RX_PIN
);

  aspbg_state_t r;
  aspbg_state_t n;

  // wires between the state logic and the leaf modules
  logic timer_tick;
  logic tx_ovf;
  logic rx_ovf;
  logic rx_force;
  logic [ASPBG_TIMER_W-1:0] tx_count;
  logic [ASPBG_TIMER_W-1:0] rx_count;
  logic fifo_valid;
  logic fifo_pop;
  logic [ASPBG_DATA_W-1:0] fifo_data;
  logic tx_tick;
  logic rx_sample;
  logic rx_fall;
  logic ext_rise;
  logic osc_rise;
  logic [3:0] last_idx;
  logic tx_free;
  logic tx_done_set;
  logic rx_done_set;
  logic rx_check;
  logic rx_accept;
  logic rx_finish;

  // writes to the data buffer only ever reach the transmit path
  aspbg_fifo #(
    .W(ASPBG_DATA_W),
    .D(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .in_valid(SERIAL_DATA_BUFFER_WR),
    .in_ready(SERIAL_DATA_BUFFER_WR_READY),
    .in_data(SERIAL_DATA_BUFFER_WDATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // visible transmit timer, counts the low byte up to overflow
  aspbg_reload_timer #(
    .W(ASPBG_TIMER_W)
  ) u_tx_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .tick(timer_tick),
    .force_load(1'b0),
    .reload(BAUD_TIMER_RELOAD_BYTE),
    .ovf(tx_ovf),
    .count(tx_count)
  );

  // hidden receive copy, same clock and reload byte, realigned on start
  aspbg_reload_timer #(
    .W(ASPBG_TIMER_W)
  ) u_rx_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .tick(timer_tick),
    .force_load(rx_force),
    .reload(BAUD_TIMER_RELOAD_BYTE),
    .ovf(rx_ovf),
    .count(rx_count)
  );

  // edges count only once the second and third synchroniser stages agree
  assign rx_fall = (r.rx_sync[1] == r.rx_sync[2]) && !r.rx_sync[2] && r.rx_level;
  assign ext_rise = (r.ext_sync[1] == r.ext_sync[2]) && r.ext_sync[2] && !r.ext_level;
  assign osc_rise = (r.osc_sync[1] == r.osc_sync[2]) && r.osc_sync[2] && !r.osc_level;

  // baud timer clock source select; a stopped timer freezes the transmit copy, and the receive copy except for a start reload
  always_comb begin
    case (aspbg_clk_src_t'(BAUD_TIMER_CLK_SEL))
      ASPBG_SRC_SYS: timer_tick = 1'b1;
      ASPBG_SRC_DIV4: timer_tick = (r.pre4 == ASPBG_PRE4_LAST);
      ASPBG_SRC_DIV12: timer_tick = (r.pre12 == ASPBG_PRE12_LAST);
      ASPBG_SRC_DIV48: timer_tick = (r.pre12 == ASPBG_PRE12_LAST) && (r.pre48 == ASPBG_PRE48_LAST);
      ASPBG_SRC_OSC8: timer_tick = osc_rise && (r.osc_cnt == ASPBG_OSC8_LAST);
      ASPBG_SRC_EXTPIN: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
    if (!BAUD_TIMER_RUN) begin
      timer_tick = 1'b0;
    end
  end

  // each bit lasts two overflows; receive samples on the first, mid-bit
  assign tx_tick = tx_ovf && r.tx_half;
  assign rx_sample = rx_ovf && !r.rx_half;
  assign last_idx = FRAME_MODE_SELECT ? ASPBG_LAST_9BIT : ASPBG_LAST_8BIT;
  assign tx_free = (r.tx_state == ASPBG_TX_IDLE) || (r.tx_cnt == last_idx);
  assign fifo_pop = tx_tick && tx_free;

  // received check bit: stop bit in 8-bit mode, ninth data bit in 9-bit mode
  assign rx_check = FRAME_MODE_SELECT ? r.rx_shift[8] : r.rx_level;
  assign rx_finish = (r.rx_state == ASPBG_RX_RECV) && rx_sample && (r.rx_cnt == last_idx);
  assign rx_accept = rx_finish && !r.rx_done && (!STOP_OR_ADDRESS_CHECK_ENABLE || rx_check);
  assign rx_done_set = rx_accept;
  assign rx_force = (r.rx_state == ASPBG_RX_IDLE) && rx_fall && RECEIVE_ENABLE_BIT;

  // next-state logic for every register of the port
  always_comb begin
    n = r;
    tx_done_set = 1'b0;

    // three-stage synchronisers; first stage feeds only the second
    n.rx_sync = {r.rx_sync[1:0], SERIAL_RX_PIN};
    n.ext_sync = {r.ext_sync[1:0], BAUD_TIMER_EXT_INPUT};
    n.osc_sync = {r.osc_sync[1:0], EXT_OSC_CLK_PIN};
    if (r.rx_sync[1] == r.rx_sync[2]) begin
      n.rx_level = r.rx_sync[2];
    end
    if (r.ext_sync[1] == r.ext_sync[2]) begin
      n.ext_level = r.ext_sync[2];
    end
    if (r.osc_sync[1] == r.osc_sync[2]) begin
      n.osc_level = r.osc_sync[2];
    end

    // free-running prescalers; divide by 48 rides on the divide by 12
    n.pre4 = r.pre4 + 2'h1;
    if (r.pre12 == ASPBG_PRE12_LAST) begin
      n.pre12 = 4'h0;
      n.pre48 = r.pre48 + 2'h1;
    end else begin
      n.pre12 = r.pre12 + 4'h1;
    end
    if (osc_rise) begin
      n.osc_cnt = r.osc_cnt + 3'h1;
    end

    // divide-by-two phases of the two overflow streams
    if (tx_ovf) begin
      n.tx_half = !r.tx_half;
    end
    if (rx_force) begin
      n.rx_half = 1'b0;
    end else if (rx_ovf) begin
      n.rx_half = !r.rx_half;
    end

    // transmitter: start bit, data lsb first, optional ninth bit, stop bit
    if (tx_tick) begin
      if (tx_free) begin
        if (fifo_valid) begin
          n.tx_state = ASPBG_TX_SEND;
          n.tx_cnt = ASPBG_START_IDX;
          n.tx_pin = 1'b0;
          n.tx_shift = FRAME_MODE_SELECT ? {1'b1, TRANSMIT_NINTH_BIT, fifo_data}
                                         : {2'b11, fifo_data};
        end else begin
          n.tx_state = ASPBG_TX_IDLE;
          n.tx_pin = 1'b1;
        end
      end else begin
        n.tx_pin = r.tx_shift[0];
        n.tx_shift = {1'b1, r.tx_shift[9:1]};
        n.tx_cnt = r.tx_cnt + 4'h1;
        if ((r.tx_cnt + 4'h1) == last_idx) begin
          tx_done_set = 1'b1;
        end
      end
    end

    // receiver: realign on start, check start at mid-bit, shift data in
    case (r.rx_state)
      ASPBG_RX_IDLE: begin
        if (rx_force) begin
          n.rx_state = ASPBG_RX_RECV;
          n.rx_cnt = ASPBG_START_IDX;
        end
      end
      ASPBG_RX_RECV: begin
        if (rx_sample) begin
          if (r.rx_cnt == ASPBG_START_IDX) begin
            // a high line at mid start bit is a glitch, not a frame
            if (r.rx_level) begin
              n.rx_state = ASPBG_RX_IDLE;
            end else begin
              n.rx_cnt = 4'h1;
            end
          end else if (r.rx_cnt == last_idx) begin
            n.rx_state = ASPBG_RX_IDLE;
            // buffer only loads on acceptance, so an overrun keeps the first byte
            if (rx_accept) begin
              n.rx_buf = FRAME_MODE_SELECT ? r.rx_shift[7:0] : r.rx_shift[8:1];
              n.rx_ninth = rx_check;
            end
          end else begin
            n.rx_shift = {r.rx_level, r.rx_shift[8:1]};
            n.rx_cnt = r.rx_cnt + 4'h1;
          end
        end
      end
      default: n.rx_state = ASPBG_RX_IDLE;
    endcase

    // sticky flags: hardware set wins over a same-cycle software clear
    n.tx_done = (r.tx_done && !TRANSMIT_DONE_CLEAR) || tx_done_set;
    n.rx_done = (r.rx_done && !RECEIVE_DONE_CLEAR) || rx_done_set;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= ASPBG_STATE_RESET;
    end else begin
      r <= n;
    end
  end

  // reads see only the receive buffer; transmit data has no read path
  assign SERIAL_DATA_BUFFER_RDATA = r.rx_buf;
  assign RECEIVED_NINTH_BIT = r.rx_ninth;
  assign TRANSMIT_DONE_FLAG = r.tx_done;
  assign RECEIVE_DONE_FLAG = r.rx_done;
  assign PORT_IRQ = PORT_IRQ_ENABLE && (r.tx_done || r.rx_done);
  assign SERIAL_TX_PIN = r.tx_pin;

  a_ti_stays_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (r.tx_done && !TRANSMIT_DONE_CLEAR) |=> r.tx_done)
    else $error("transmit done flag dropped without a clear");

  a_ri_stays_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (r.rx_done && !RECEIVE_DONE_CLEAR) |=> r.rx_done)
    else $error("receive done flag dropped without a clear");

  a_irq_on_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ($rose(r.tx_done) || $rose(r.rx_done)) && PORT_IRQ_ENABLE |-> PORT_IRQ)
    else $error("no interrupt request on a new done flag");

  a_tx_idle_high: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (r.tx_state == ASPBG_TX_IDLE) |-> r.tx_pin)
    else $error("transmit line not high while idle");

  a_ti_at_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(r.tx_done) |-> r.tx_pin && (r.tx_cnt == $past(last_idx)) && $past(tx_tick))
    else $error("transmit done not set at stop bit start");

  a_start_bit_low: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    fifo_pop && fifo_valid |=> !r.tx_pin && (r.tx_state == ASPBG_TX_SEND))
    else $error("frame did not open with a low start bit");

  a_rx_disabled_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (r.rx_state == ASPBG_RX_IDLE) && !RECEIVE_ENABLE_BIT |=> (r.rx_state == ASPBG_RX_IDLE))
    else $error("receiver started while disabled");

  a_start_reload: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rx_force |=> (rx_count == $past(BAUD_TIMER_RELOAD_BYTE)) && !r.rx_half)
    else $error("receive timer not reloaded on start");

  a_overrun_keeps: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    r.rx_done && !RECEIVE_DONE_CLEAR |=> $stable(r.rx_buf) && $stable(r.rx_ninth))
    else $error("receive buffer changed while a byte was pending");

  a_ri_needs_accept: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(r.rx_done) |-> $past(rx_finish) && !$past(r.rx_done))
    else $error("receive done set without an accepted frame");

  // timer, shifter and buffer invariants; a stopped timer must freeze the transmit copy, and the receive copy unless a start forces a reload
  a_tx_timer_frozen: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !BAUD_TIMER_RUN |=> $stable(tx_count))
    else $error("transmit timer counted while stopped");

  a_rx_copy_frozen: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !BAUD_TIMER_RUN && !rx_force |=> $stable(rx_count))
    else $error("receive timer counted while stopped");

  a_rx_half_toggle: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rx_ovf |=> r.rx_half != $past(r.rx_half))
    else $error("receive divider missed an overflow");

  a_tx_shift_lsb: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    tx_tick && !tx_free |=> r.tx_pin == $past(r.tx_shift[0]))
    else $error("transmit bit not taken from the shifter bottom");

  a_rxbuf_only_accept: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !rx_accept |=> $stable(r.rx_buf) && $stable(r.rx_ninth))
    else $error("receive buffer changed without acceptance");

  a_ri_on_accept: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rx_accept |=> r.rx_done)
    else $error("accepted frame did not set receive done");

  a_ninth_is_check: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rx_accept |=> r.rx_ninth == $past(rx_check))
    else $error("received ninth bit does not hold the check bit");

  a_write_queued: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    SERIAL_DATA_BUFFER_WR && SERIAL_DATA_BUFFER_WR_READY |=> fifo_valid)
    else $error("accepted write did not reach the transmit queue");

  a_frame_loads_byte: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    fifo_pop && fifo_valid |=> r.tx_shift[7:0] == $past(fifo_data))
    else $error("frame did not load the queued byte");

  a_rx_stop_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rx_finish |=> r.rx_state == ASPBG_RX_IDLE)
    else $error("receiver did not return to idle after the stop sample");

  a_tx_idle_line: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (r.tx_state == ASPBG_TX_IDLE) && !fifo_valid |=> r.tx_pin)
    else $error("transmit line left idle with nothing queued");

  a_sel_no_ticks: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    BAUD_TIMER_CLK_SEL > ASPBG_SRC_EXTPIN |-> !timer_tick)
    else $error("spare clock source produced a timer tick");

endmodule : aspbg_top

// ===== aspbg_remote.sv
// remote serial transceiver model: drives the receive line, decodes the transmit line
`timescale 1ns/1ns
module aspbg_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_cyc = 32;
  int nbits = 8;
  logic [8:0] rx_q[$];
  logic stop_q[$];
  logic [8:0] word;
  logic stop;

  // line idles high between frames
  initial line_out = 1'b1;

  // start bit, data lsb first (ninth in 9-bit mode), stop, then back to idle
  task automatic send(input logic [8:0] d, input logic stop_lvl);
    for (int i = -1; i <= nbits; i++) begin
      @(posedge clk);
      line_out <= (i < 0) ? 1'b0 : (i == nbits) ? stop_lvl : d[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask : send

  // decode frames sampled at bit centres, counted from the falling start edge
  always begin
    @(negedge line_in);
    word = '0;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge clk);
      word[i] = line_in;
    end
    repeat (bit_cyc) @(posedge clk);
    stop = line_in;
    rx_q.push_back(word);
    stop_q.push_back(stop);
  end
endmodule : aspbg_remote

// ===== test_aspbg_top.sv
// self-checking testbench for the serial port with baud generator
`timescale 1ns/1ns
module test_aspbg_top;
  import aspbg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic wr_ready, tx_done, rx_done, irq, ninth_rx, tx_pin, rx_line;
  logic [7:0] rdata;
  logic mode = 1'b0, mce = 1'b0, ren = 1'b1, ninth_tx = 1'b0;
  logic tx_clr = 1'b0, rx_clr = 1'b0, irq_en = 1'b1, run = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [7:0] reload = 8'hf0;
  logic [2:0] ext_cnt = 3'h0;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int bit_tab[6] = '{32, 64, 48, 96, 64, 64};
  logic [7:0] rel_tab[6] = '{8'hf0, 8'hf8, 8'hfe, 8'hff, 8'hff, 8'hfc};

  aspbg_top aspbg_top_i (.SYS_CLK(clk), .RST_B(rst_b), .SERIAL_DATA_BUFFER_WR(wr),
    .SERIAL_DATA_BUFFER_WDATA(wdata), .SERIAL_DATA_BUFFER_WR_READY(wr_ready),
    .SERIAL_DATA_BUFFER_RDATA(rdata), .FRAME_MODE_SELECT(mode), .STOP_OR_ADDRESS_CHECK_ENABLE(mce),
    .RECEIVE_ENABLE_BIT(ren), .TRANSMIT_NINTH_BIT(ninth_tx), .RECEIVED_NINTH_BIT(ninth_rx),
    .TRANSMIT_DONE_FLAG(tx_done), .RECEIVE_DONE_FLAG(rx_done), .TRANSMIT_DONE_CLEAR(tx_clr),
    .RECEIVE_DONE_CLEAR(rx_clr), .PORT_IRQ_ENABLE(irq_en), .PORT_IRQ(irq), .BAUD_TIMER_RUN(run),
    .BAUD_TIMER_CLK_SEL(sel), .BAUD_TIMER_RELOAD_BYTE(reload), .EXT_OSC_CLK_PIN(ext_cnt[1]),
    .BAUD_TIMER_EXT_INPUT(ext_cnt[2]), .SERIAL_TX_PIN(tx_pin), .SERIAL_RX_PIN(rx_line));
  aspbg_remote aspbg_remote_i (.clk(clk), .line_in(tx_pin), .line_out(rx_line));

  initial begin
    forever #20 clk = ~clk;
  end

  // free-running external clock sources: oscillator every 4 cycles, timer pin every 8
  always @(posedge clk) begin
    ext_cnt <= ext_cnt + 3'h1;
  end

  // watchdog well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      errors++;
      $display("BAD watchdog expected finish seen hang");
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_byte(input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_byte

  // one-cycle clear pulse, then settle to the next falling edge
  task automatic clr(input bit rx);
    @(posedge clk);
    if (rx) rx_clr <= 1'b1;
    else tx_clr <= 1'b1;
    @(posedge clk);
    rx_clr <= 1'b0;
    tx_clr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : clr

  // bounded wait for a done flag, sampled settled
  task automatic await_flag(input bit rx, input int lim);
    int n;
    n = 0;
    while (((rx ? rx_done : tx_done) !== 1'b1) && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(rx ? "rx flag" : "tx flag", 9'h001, {8'h00, rx ? rx_done : tx_done});
  endtask : await_flag

  // bounded wait for a frame at the remote end, then compare data and stop level
  task automatic expect_tx(input logic [8:0] exp, input int lim);
    int n;
    n = 0;
    while (aspbg_remote_i.rx_q.size() == 0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("tx frame count", 9'h001, (aspbg_remote_i.rx_q.size() > 0) ? 9'h001 : 9'h000);
    if (aspbg_remote_i.rx_q.size() > 0) begin
      check("tx frame", exp, aspbg_remote_i.rx_q.pop_front());
      check("tx stop", 9'h001, {8'h00, aspbg_remote_i.stop_q.pop_front()});
    end
  endtask : expect_tx

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("tx idle", 9'h001, {8'h00, tx_pin});
    check("reset flags", 9'h000, {6'h00, tx_done, rx_done, irq});
    check("reset rdata", 9'h000, {1'b0, rdata});
    check("reset ready", 9'h001, {8'h00, wr_ready});
    $display("test reset done");

    wr_byte(8'ha5);
    // the first overflow after reset takes a full 256 ticks, so allow for it
    await_flag(0, 700);
    check("stop on line at flag", 9'h001, {8'h00, tx_pin});
    check("frame open at flag", 9'h000, 9'(aspbg_remote_i.rx_q.size()));
    check("irq on tx", 9'h001, {8'h00, irq});
    expect_tx(9'h0a5, 400);
    check("tx flag held", 9'h001, {8'h00, tx_done});
    clr(0);
    check("tx flag cleared", 9'h000, {7'h00, tx_done, irq});
    $display("test transmit done");

    aspbg_remote_i.send(9'h03c, 1'b1);
    await_flag(1, 400);
    check("rx data", 9'h03c, {1'b0, rdata});
    check("rx stop to ninth", 9'h001, {8'h00, ninth_rx});
    irq_en <= 1'b0;
    @(negedge clk);
    check("irq masked", 9'h000, {8'h00, irq});
    irq_en <= 1'b1;
    wr_byte(8'h5a);
    @(negedge clk);
    check("write leaves rx buffer", 9'h03c, {1'b0, rdata});
    expect_tx(9'h05a, 400);
    aspbg_remote_i.send(9'h077, 1'b1);
    repeat (40) @(negedge clk);
    check("overrun keeps first", 9'h03c, {1'b0, rdata});
    check("overrun flag", 9'h001, {8'h00, rx_done});
    clr(1);
    $display("test receive done");

    aspbg_remote_i.send(9'h011, 1'b1);
    await_flag(1, 400);
    fork
      aspbg_remote_i.send(9'h022, 1'b1);
      begin
        repeat (100) @(posedge clk);
        clr(1);
        check("buffer held while shifting", 9'h011, {1'b0, rdata});
      end
    join
    await_flag(1, 400);
    check("second byte", 9'h022, {1'b0, rdata});
    clr(1);
    mce <= 1'b1;
    aspbg_remote_i.send(9'h044, 1'b0);
    repeat (40) @(negedge clk);
    check("bad stop refused", 9'h022, {rx_done, rdata});
    mce <= 1'b0;
    aspbg_remote_i.send(9'h045, 1'b0);
    await_flag(1, 400);
    check("unchecked stop", 9'h045, {ninth_rx, rdata});
    clr(1);
    ren <= 1'b0;
    aspbg_remote_i.send(9'h099, 1'b1);
    repeat (40) @(negedge clk);
    check("disabled rx ignored", 9'h045, {rx_done, rdata});
    ren <= 1'b1;
    $display("test acceptance done");

    mode <= 1'b1;
    ninth_tx <= 1'b1;
    aspbg_remote_i.nbits = 9;
    wr_byte(8'h81);
    expect_tx(9'h181, 450);
    mce <= 1'b1;
    aspbg_remote_i.send(9'h1c6, 1'b0);
    await_flag(1, 450);
    check("ninth bit rx", 9'h1c6, {ninth_rx, rdata});
    clr(1);
    aspbg_remote_i.send(9'h0c7, 1'b1);
    repeat (40) @(negedge clk);
    check("address check refuses", 9'h000, {8'h00, rx_done});
    mce <= 1'b0;
    mode <= 1'b0;
    aspbg_remote_i.nbits = 8;
    clr(0);
    $display("test nine bit done");

    run <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr_byte(8'h10 + 8'(i));
      @(negedge clk);
      check("ready while filling", (i < 7) ? 9'h001 : 9'h000, {8'h00, wr_ready});
    end
    run <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      expect_tx(9'h010 + 9'(i), 400);
    end
    repeat (400) @(negedge clk);
    check("refused write dropped", 9'h000, 9'(aspbg_remote_i.rx_q.size()));
    clr(0);
    $display("test fifo done");

    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sel <= 3'(i);
      reload <= rel_tab[i];
      aspbg_remote_i.bit_cyc = bit_tab[i];
      wr_byte(8'h60 + 8'(i));
      expect_tx(9'h060 + 9'(i), 12 * bit_tab[i] + 200);
      aspbg_remote_i.send(9'h0c0 + 9'(i), 1'b1);
      await_flag(1, 4 * bit_tab[i]);
      check("rx at rate", 9'h0c0 + 9'(i), {1'b0, rdata});
      clr(1);
      clr(0);
    end
    // spare source codes give no ticks, so a queued byte never leaves
    sel <= 3'h7;
    wr_byte(8'h77);
    repeat (400) @(negedge clk);
    check("spare source silent", 9'h000, 9'(aspbg_remote_i.rx_q.size()));
    $display("test clock sources done");
    conclude();
  end
endmodule : test_aspbg_top
